//--- bads_pkg.sv
// Shared constants, types and field layouts for the board address select decode
package bads_pkg;

  localparam int ADR_W = 24;
  localparam int DAT_W = 8;
  localparam int PAGE_W = 4;
  localparam int BND_W = 8;
  localparam int OFS_W = 20;
  localparam int PAGE_LSB = 20;
  localparam int BND_LSB = 12;
  localparam int IO_TOP_LSB = 12;
  localparam int IO_MID_LSB = 8;
  localparam int IO_NIB_W = 4;
  localparam int IO_LINE6 = 6;
  localparam int IO_LINE7 = 7;
  localparam int IO_LINE4 = 4;
  localparam int IO_LINE5 = 5;
  localparam int IO_LOW_W = 4;

  // Window arithmetic is one bit wider than the page offset so the end never wraps
  localparam int WIN_W = OFS_W + 1;

  localparam logic [PAGE_W-1:0] PAGE_DEFAULT = 4'h0;
  localparam logic [BND_W-1:0] BND_DEFAULT = 8'h00;
  localparam logic [BND_W-1:0] BND_DEFAULT_32K = 8'h08;
  localparam logic [IO_LOW_W-1:0] IO_LINE_LOW_DEFAULT = 4'h0;

  localparam logic [WIN_W-1:0] CAP_16K = 21'h004000;
  localparam logic [WIN_W-1:0] CAP_32K = 21'h008000;
  localparam logic [WIN_W-1:0] CAP_64K = 21'h010000;
  localparam logic [WIN_W-1:0] CAP_128K = 21'h020000;
  localparam logic [WIN_W-1:0] CAP_256K = 21'h040000;

  // Advanced write: command may lead the data by up to this time
  localparam int CLK_PERIOD_NS = 25;
  localparam int ADV_WRITE_NS = 500;
  localparam int ADV_WRITE_CYC = (ADV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADV_CNT_W = 5;
  localparam logic [ADV_CNT_W-1:0] ADV_CNT_LOAD = ADV_CNT_W'(ADV_WRITE_CYC - 1);
  localparam logic [ADV_CNT_W-1:0] ADV_CNT_ZERO = 5'h00;

  // Parity flag register byte layout
  localparam int PFR_ERR0_BIT = 0;
  localparam int PFR_ERR1_BIT = 1;
  localparam int PFR_TYPE0_BIT = 4;
  localparam int PFR_TYPE1_BIT = 5;

  typedef enum logic [2:0] {
    BADS_CAP_16K,
    BADS_CAP_32K,
    BADS_CAP_64K,
    BADS_CAP_128K,
    BADS_CAP_256K
  } bads_variant_e;

  // Bus lines after inversion: one means asserted
  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic mrd;
    logic mwr;
    logic ird;
    logic iwr;
    logic bhe;
    logic [DAT_W-1:0] dat;
  } bads_bus_s;

  typedef struct packed {
    logic top_en;
    logic mid_en;
    logic low_en;
    logic line6_high;
    logic [IO_LOW_W-1:0] line_low;
  } bads_io_cfg_s;

endpackage

//--- bads_board_select.sv
// Memory window and parity-port select logic of the RAM board
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

module bads_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] stable_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_stable;

  // A bit changes only once the second and third stages agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      next_stable[i] = (s2[i] == s3[i]) ? s2[i] : stable_o[i];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      stable_o <= '0;
    end
    else
    begin
      s1 <= raw_i;
      s2 <= s1;
      s3 <= s2;
      stable_o <= next_stable;
    end
  end
endmodule

// What this block does
// RL1 - Compare top four address lines with page setting; sixteen 1 MB pages
// RL2 - Page setting is plain binary, first setting MSB, fitted means one
// RL3 - No page selections fitted gives page zero
// RL4 - Window never crosses a page; page field must equal configured page
// RL5 - Compare address lines 19..12 with boundary setting; any 4k start
// RL6 - Boundary setting is plain binary, first setting MSB, fitted means one
// RL7 - Default boundary is offset zero, except 32k variant at offset 08000
// RL8 - Start equals page times 1 MB plus boundary times 4k; 256 starts per page
// RL9 - Configurer keeps start below capacity limit or upper part is lost
// RL10 - Whole capacity mapped contiguously in one page from the start
// RL11 - Banks work together; bank zero odd byte, bank one even byte
// RL12 - Delayed write: master asserts write 50 ns after data and address
// RL13 - 64k variant may use advanced write, command up to 500 ns early
// RL14 - I/O decode groups: top nibble, mid nibble, low byte, each enabled
// RL15 - Line 6 matched low or high, only while low byte group enabled
// RL16 - Lines 0 to 3 must be low when option fitted, else high
// RL17 - Matching I/O decode asserts chip select for parity flag register
// RL18 - Factory default places parity flag register at port 000F
// RL19 - On 16k variant an option disables parity flag function
// RL20 - Enabled lines without polarity option must be inactive to match
// RL21 - I/O read returns flag register; write clears it and sets parity type
// RL22 - Board select only for memory commands inside start to start plus size
// RL23 - Configuration inputs are static and sampled continuously
module bads_board_select (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [bads_pkg::ADR_W-1:0] adr_n_i,
  input wire logic mrdc_n_i,
  input wire logic mwtc_n_i,
  input wire logic iord_n_i,
  input wire logic iowc_n_i,
  input wire logic bhen_n_i,
  input wire logic [bads_pkg::DAT_W-1:0] dat_n_i,
  input wire bads_pkg::bads_variant_e board_variant_i,
  input wire logic cfg_factory_default_i,
  input wire logic [bads_pkg::PAGE_W-1:0] page_sel_i,
  input wire logic [bads_pkg::BND_W-1:0] boundary_sel_i,
  input wire logic delayed_write_select_i,
  input wire logic advanced_write_select_i,
  input wire logic io_decode_top_nibble_en_i,
  input wire logic io_decode_mid_nibble_en_i,
  input wire logic io_decode_low_byte_en_i,
  input wire logic io_line6_low_match_i,
  input wire logic io_line6_high_match_i,
  input wire logic [bads_pkg::IO_LOW_W-1:0] io_line_low_match_i,
  input wire logic parity_flag_disable_i,
  input wire logic [1:0] parity_err_bank_i,
  output logic board_sel_o,
  output logic mem_rd_req_o,
  output logic mem_wr_req_o,
  output logic bank0_en_o,
  output logic bank1_en_o,
  output logic parity_reg_chip_select_n_o,
  output logic [bads_pkg::DAT_W-1:0] io_rd_data_o,
  output logic io_rd_drive_n_o,
  output logic [1:0] parity_type_o
);
  import bads_pkg::*;

  typedef enum {WR_IDLE, WR_HOLD, WR_GO} bads_wr_state_e;

  bads_bus_s raw_bus;
  bads_bus_s bus;
  logic [PAGE_W-1:0] page;
  logic [BND_W-1:0] bnd;
  bads_io_cfg_s io_cfg;
  logic adv_mode;
  logic parity_off;
  logic [WIN_W-1:0] cap;
  logic [WIN_W-1:0] win_start;
  logic [WIN_W-1:0] win_end;
  logic [WIN_W-1:0] ofs;
  logic mem_hit;
  logic io_hit;
  logic io_cs;
  logic iwr_prev;
  logic [1:0] err_flags;
  logic [1:0] next_err_flags;
  logic [1:0] next_parity_type;
  logic next_iwr_prev;
  bads_wr_state_e wr_state;
  bads_wr_state_e next_wr_state;
  logic [ADV_CNT_W-1:0] adv_cnt;
  logic [ADV_CNT_W-1:0] next_adv_cnt;
  logic next_board_sel;
  logic next_mem_rd_req;
  logic next_bank0_en;
  logic next_bank1_en;
  logic next_cs_n;
  logic [DAT_W-1:0] next_io_rd_data;
  logic next_io_rd_drive_n;

  assign raw_bus = '{adr: ~adr_n_i, mrd: ~mrdc_n_i, mwr: ~mwtc_n_i, ird: ~iord_n_i,
                     iwr: ~iowc_n_i, bhe: ~bhen_n_i, dat: ~dat_n_i};

  bads_sync #(.W($bits(bads_bus_s))) u_bus_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .raw_i(raw_bus),
    .stable_o(bus)
  );

  // Configuration straps, read continuously with no handshake
  always_comb
  begin
    page = cfg_factory_default_i ? PAGE_DEFAULT : page_sel_i; // RL2 RL3 RL23
    if (cfg_factory_default_i) // RL7
    begin
      bnd = (board_variant_i == BADS_CAP_32K) ? BND_DEFAULT_32K : BND_DEFAULT;
    end
    else
    begin
      bnd = boundary_sel_i; // RL6
    end
    if (cfg_factory_default_i) // RL18
    begin
      io_cfg = '{top_en: 1'b1, mid_en: 1'b1, low_en: 1'b1, line6_high: 1'b0,
                 line_low: IO_LINE_LOW_DEFAULT};
    end
    else
    begin
      io_cfg = '{top_en: io_decode_top_nibble_en_i, mid_en: io_decode_mid_nibble_en_i,
                 low_en: io_decode_low_byte_en_i,
                 line6_high: io_line6_high_match_i & ~io_line6_low_match_i,
                 line_low: io_line_low_match_i};
    end
    adv_mode = !cfg_factory_default_i && advanced_write_select_i && !delayed_write_select_i
               && (board_variant_i == BADS_CAP_64K); // RL13
    parity_off = !cfg_factory_default_i && parity_flag_disable_i
                 && (board_variant_i == BADS_CAP_16K); // RL19
  end

  // Memory window decode
  always_comb
  begin
    case (board_variant_i)
      BADS_CAP_16K: cap = CAP_16K;
      BADS_CAP_32K: cap = CAP_32K;
      BADS_CAP_64K: cap = CAP_64K;
      BADS_CAP_128K: cap = CAP_128K;
      BADS_CAP_256K: cap = CAP_256K;
      default: cap = CAP_16K;
    endcase
    win_start = {1'b0, bnd, {BND_LSB{1'b0}}}; // RL5 RL8
    win_end = win_start + cap; // RL10
    ofs = {1'b0, bus.adr[OFS_W-1:0]};
    // Offset is below one page, so a window reaching past the page is cut off
    mem_hit = (bus.adr[ADR_W-1:PAGE_LSB] == page) // RL1 RL4
              && (ofs >= win_start) && (ofs < win_end); // RL22 RL9
  end

  // I/O port decode for the parity flag register
  always_comb
  begin
    io_hit = 1'b1;
    if (io_cfg.top_en && (bus.adr[IO_TOP_LSB +: IO_NIB_W] != '0)) // RL14 RL20
    begin
      io_hit = 1'b0;
    end
    if (io_cfg.mid_en && (bus.adr[IO_MID_LSB +: IO_NIB_W] != '0)) // RL14 RL20
    begin
      io_hit = 1'b0;
    end
    if (io_cfg.low_en) // RL14
    begin
      if (bus.adr[IO_LINE7] || bus.adr[IO_LINE5] || bus.adr[IO_LINE4]) // RL20
      begin
        io_hit = 1'b0;
      end
      if (bus.adr[IO_LINE6] != io_cfg.line6_high) // RL15
      begin
        io_hit = 1'b0;
      end
    end
    if (bus.adr[IO_LOW_W-1:0] != ~io_cfg.line_low) // RL16
    begin
      io_hit = 1'b0;
    end
    io_cs = io_hit && (bus.ird || bus.iwr) && !parity_off; // RL17 RL19
  end

  // Select, bank and read outputs
  always_comb
  begin
    next_board_sel = mem_hit && (bus.mrd || bus.mwr); // RL22
    next_mem_rd_req = mem_hit && bus.mrd;
    // Word transfer on an even address enables both banks together
    next_bank1_en = next_board_sel && (!bus.adr[0]); // RL11
    next_bank0_en = next_board_sel && (bus.adr[0] || bus.bhe); // RL11
    next_cs_n = !io_cs; // RL17
    next_io_rd_drive_n = !(io_cs && bus.ird);
    next_io_rd_data = '0;
    if (io_cs && bus.ird) // RL21
    begin
      next_io_rd_data[PFR_ERR0_BIT] = err_flags[0];
      next_io_rd_data[PFR_ERR1_BIT] = err_flags[1];
      next_io_rd_data[PFR_TYPE0_BIT] = parity_type_o[0];
      next_io_rd_data[PFR_TYPE1_BIT] = parity_type_o[1];
    end
  end

  // Write command: delayed mode goes at once, advanced mode waits out the ADV_WRITE_CYC cycle count
  always_comb
  begin
    next_wr_state = wr_state;
    next_adv_cnt = adv_cnt;
    case (wr_state)
      WR_IDLE:
      begin
        if (bus.mwr && mem_hit)
        begin
          if (adv_mode) // RL13
          begin
            next_wr_state = WR_HOLD;
            next_adv_cnt = ADV_CNT_LOAD;
          end
          else
          begin
            next_wr_state = WR_GO; // RL12
          end
        end
      end
      WR_HOLD:
      begin
        if (!bus.mwr)
        begin
          next_wr_state = WR_IDLE;
        end
        else if (adv_cnt == ADV_CNT_ZERO) // RL13
        begin
          next_wr_state = WR_GO;
        end
        else
        begin
          next_adv_cnt = adv_cnt - 1'b1;
        end
      end
      WR_GO:
      begin
        if (!bus.mwr)
        begin
          next_wr_state = WR_IDLE;
        end
      end
      default:
      begin
        next_wr_state = WR_IDLE;
      end
    endcase
  end

  // Parity flag register: error set wins over a clearing write
  always_comb
  begin
    next_iwr_prev = io_cs && bus.iwr;
    next_err_flags = err_flags;
    next_parity_type = parity_type_o;
    if (io_cs && bus.iwr && !iwr_prev) // RL21
    begin
      next_err_flags = '0;
      next_parity_type = {bus.dat[PFR_TYPE1_BIT], bus.dat[PFR_TYPE0_BIT]};
    end
    if (!parity_off) // RL19
    begin
      next_err_flags = next_err_flags | parity_err_bank_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      wr_state <= WR_IDLE;
      adv_cnt <= ADV_CNT_ZERO;
      board_sel_o <= 1'b0;
      mem_rd_req_o <= 1'b0;
      mem_wr_req_o <= 1'b0;
      bank0_en_o <= 1'b0;
      bank1_en_o <= 1'b0;
      parity_reg_chip_select_n_o <= 1'b1;
      io_rd_data_o <= '0;
      io_rd_drive_n_o <= 1'b1;
      iwr_prev <= 1'b0;
      err_flags <= '0;
      parity_type_o <= '0;
    end
    else
    begin
      wr_state <= next_wr_state;
      adv_cnt <= next_adv_cnt;
      board_sel_o <= next_board_sel;
      mem_rd_req_o <= next_mem_rd_req;
      mem_wr_req_o <= (next_wr_state == WR_GO);
      bank0_en_o <= next_bank0_en;
      bank1_en_o <= next_bank1_en;
      parity_reg_chip_select_n_o <= next_cs_n;
      io_rd_data_o <= next_io_rd_data;
      io_rd_drive_n_o <= next_io_rd_drive_n;
      iwr_prev <= next_iwr_prev;
      err_flags <= next_err_flags;
      parity_type_o <= next_parity_type;
    end
  end
endmodule

//--- bads_board_select_props.sv
// Checker tying the select outputs to the bus commands and addresses behind them
`timescale 1ns/1ps
module bads_board_select_props (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [bads_pkg::ADR_W-1:0] adr_n_i,
  input wire logic mrdc_n_i,
  input wire logic mwtc_n_i,
  input wire logic iord_n_i,
  input wire logic iowc_n_i,
  input wire logic bhen_n_i,
  input wire bads_pkg::bads_variant_e board_variant_i,
  input wire logic cfg_factory_default_i,
  input wire logic [bads_pkg::PAGE_W-1:0] page_sel_i,
  input wire logic [bads_pkg::BND_W-1:0] boundary_sel_i,
  input wire logic delayed_write_select_i,
  input wire logic advanced_write_select_i,
  input wire logic parity_flag_disable_i,
  input wire logic board_sel_o,
  input wire logic mem_rd_req_o,
  input wire logic mem_wr_req_o,
  input wire logic bank0_en_o,
  input wire logic bank1_en_o,
  input wire logic parity_reg_chip_select_n_o,
  input wire logic io_rd_drive_n_o
);
  import bads_pkg::*;
  logic [23:0] adr;
  logic [3:0] pg;
  logic [20:0] st;
  logic [20:0] cap;
  logic fd;
  logic advm;
  assign adr = ~adr_n_i;
  assign fd = cfg_factory_default_i;
  assign pg = fd ? 4'h0 : page_sel_i;
  assign st = {1'b0, fd ? ((board_variant_i == BADS_CAP_32K) ? 8'h08 : 8'h00) : boundary_sel_i,
    12'h000};
  assign cap = 21'h004000 << board_variant_i;
  assign advm = (board_variant_i == BADS_CAP_64K) && advanced_write_select_i &&
    !delayed_write_select_i && !fd;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // A pin change reaches the registered outputs five edges later
  a_sel_has_cmd: assert property (board_sel_o |-> $past(!mrdc_n_i || !mwtc_n_i, 5))
    else $error("board select without memory command");
  a_sel_in_page: assert property (board_sel_o |-> $past(adr[23:20], 5) == pg)
    else $error("board select outside configured page");
  a_sel_in_window: assert property (board_sel_o |-> ({1'b0, $past(adr[19:0], 5)} >= st) &&
    ({1'b0, $past(adr[19:0], 5)} < st + cap)) else $error("board select outside window");
  a_bank1_even: assert property (bank1_en_o |-> board_sel_o && $past(!adr[0], 5))
    else $error("bank one enabled on odd address");
  a_bank0_odd: assert property (bank0_en_o |-> $past(adr[0] || !bhen_n_i, 5))
    else $error("bank zero enabled on even byte");
  a_rd_req_cause: assert property (mem_rd_req_o |-> board_sel_o && $past(!mrdc_n_i, 5))
    else $error("read request without read command");
  a_delayed_write: assert property ($rose(board_sel_o) && $past(!mwtc_n_i, 5) && !advm
    |-> mem_wr_req_o) else $error("delayed write request late");
  a_adv_write_wait: assert property ($rose(mem_wr_req_o) && advm |-> $past(board_sel_o, 20))
    else $error("advanced write request too early");
  a_cs_has_io: assert property (!parity_reg_chip_select_n_o
    |-> $past(!iord_n_i || !iowc_n_i, 5)) else $error("chip select without I/O command");
  a_default_port: assert property (fd && !parity_reg_chip_select_n_o
    |-> $past(adr[15:0], 5) == 16'h000F) else $error("default port not 000F");
  a_parity_off: assert property (board_variant_i == BADS_CAP_16K && parity_flag_disable_i
    && !fd |-> parity_reg_chip_select_n_o) else $error("chip select while disabled");
  a_rd_drive: assert property (!io_rd_drive_n_o |-> !parity_reg_chip_select_n_o &&
    $past(!iord_n_i, 5)) else $error("read data driven outside port read");
endmodule

bind bads_board_select bads_board_select_props bads_board_select_props_i (.core_clk_i, .rstn_i,
  .adr_n_i, .mrdc_n_i, .mwtc_n_i, .iord_n_i, .iowc_n_i, .bhen_n_i, .board_variant_i,
  .cfg_factory_default_i, .page_sel_i, .boundary_sel_i, .delayed_write_select_i,
  .advanced_write_select_i, .parity_flag_disable_i, .board_sel_o, .mem_rd_req_o, .mem_wr_req_o,
  .bank0_en_o, .bank1_en_o, .parity_reg_chip_select_n_o, .io_rd_drive_n_o);

//--- bads_bus_master.sv
// Bus master model driving active-low address, command and data lines
`timescale 1ns/1ps
module bads_bus_master (
  input wire logic core_clk_i,
  output logic [23:0] adr_n_o,
  output logic [3:0] cmd_n_o,
  output logic bhen_n_o,
  output logic [7:0] dat_n_o
);
  initial
  begin
    adr_n_o = '1;
    cmd_n_o = '1;
    bhen_n_o = 1'b1;
    dat_n_o = '1;
  end
  // Command index: 0 memory read, 1 memory write, 2 I/O read, 3 I/O write
  task automatic start(input int k, input logic [23:0] a, input logic [7:0] d, input logic bhe,
    input bit adv);
    @(posedge core_clk_i);
    adr_n_o <= ~a;
    bhen_n_o <= ~bhe;
    if (!adv)
    begin
      dat_n_o <= ~d;
      repeat (2) @(posedge core_clk_i);
    end
    cmd_n_o[k] <= 1'b0;
    if (adv)
    begin
      repeat (10) @(posedge core_clk_i);
      dat_n_o <= ~d;
    end
  endtask
  // Released lines return to the inactive terminator level
  task automatic stop();
    @(posedge core_clk_i);
    cmd_n_o <= '1;
    repeat (2) @(posedge core_clk_i);
    adr_n_o <= '1;
    bhen_n_o <= 1'b1;
    dat_n_o <= '1;
  endtask
endmodule

//--- test_bads_board_select.sv
// Self-checking bench for the board address select decode
`timescale 1ns/1ps
module test_bads_board_select;
  import bads_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [23:0] adr_n;
  logic [3:0] cmd_n;
  logic bhen_n;
  logic [7:0] dat_n;
  bads_variant_e var_q = BADS_CAP_16K;
  logic fd = 1'b1;
  logic [3:0] pg = 4'h0;
  logic [7:0] bnd = 8'h00;
  logic dly = 1'b1;
  logic adv = 1'b0;
  logic [2:0] ioen = 3'h7;
  logic l6l = 1'b1;
  logic l6h = 1'b0;
  logic [3:0] ll = 4'h0;
  logic pdis = 1'b0;
  logic [1:0] perr = 2'h0;
  logic sel, rdq, wrq, b0, b1, cs_n, drv_n;
  logic [7:0] rdat;
  logic [1:0] ptype;
  logic [23:0] a;
  logic [7:0] d;
  logic [1:0] ty = 2'h0;
  logic [1:0] e2;
  int miscompares = 0;
  int cmp_count = 0;
  int t, cyc = 0, sel_at = 0, wr_at = 0;
  bads_bus_master bads_bus_master_i (.core_clk_i, .adr_n_o(adr_n), .cmd_n_o(cmd_n),
    .bhen_n_o(bhen_n), .dat_n_o(dat_n));
  bads_board_select bads_board_select_i (.core_clk_i, .rstn_i, .adr_n_i(adr_n),
    .mrdc_n_i(cmd_n[0]), .mwtc_n_i(cmd_n[1]), .iord_n_i(cmd_n[2]), .iowc_n_i(cmd_n[3]),
    .bhen_n_i(bhen_n), .dat_n_i(dat_n), .board_variant_i(var_q), .cfg_factory_default_i(fd),
    .page_sel_i(pg), .boundary_sel_i(bnd), .delayed_write_select_i(dly),
    .advanced_write_select_i(adv), .io_decode_top_nibble_en_i(ioen[2]),
    .io_decode_mid_nibble_en_i(ioen[1]), .io_decode_low_byte_en_i(ioen[0]),
    .io_line6_low_match_i(l6l), .io_line6_high_match_i(l6h), .io_line_low_match_i(ll),
    .parity_flag_disable_i(pdis), .parity_err_bank_i(perr), .board_sel_o(sel),
    .mem_rd_req_o(rdq), .mem_wr_req_o(wrq), .bank0_en_o(b0), .bank1_en_o(b1),
    .parity_reg_chip_select_n_o(cs_n), .io_rd_data_o(rdat), .io_rd_drive_n_o(drv_n),
    .parity_type_o(ptype));
  initial forever #12.5 core_clk_i = ~core_clk_i;
  // Counted on the falling edge so rising-edge output events read a settled count
  always @(negedge core_clk_i) cyc <= cyc + 1;
  always @(posedge sel) sel_at = cyc;
  always @(posedge wrq) wr_at = cyc;
  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  function automatic int st();
    return (fd ? 0 : pg) * 'h100000 + (fd ? (var_q == BADS_CAP_32K ? 8 : 0) : bnd) * 4096;
  endfunction
  function automatic bit in_win(input logic [23:0] x);
    int o = x[19:0];
    int s = st() % 'h100000;
    return x[23:20] == (fd ? 4'h0 : pg) && o >= s && o < s + ('h4000 << var_q);
  endfunction
  function automatic bit io_hit(input logic [23:0] x);
    logic [2:0] e = fd ? 3'h7 : ioen;
    logic hh = !fd && l6h && !l6l;
    return (!e[2] || x[15:12] == 4'h0) && (!e[1] || x[11:8] == 4'h0) &&
      (!e[0] || x[7:4] == {1'b0, hh, 2'b00}) && x[3:0] == (fd ? 4'hF : ~ll) &&
      !(var_q == BADS_CAP_16K && pdis && !fd);
  endfunction
  task automatic mem(input logic [23:0] x, input int k);
    logic bhe;
    bit h;
    bhe = 1'($urandom);
    h = in_win(x);
    bads_bus_master_i.start(k, x, 8'h5A, bhe, 1'b0);
    tick(6);
    chk({sel, rdq, wrq, b1, b0}, {h, h && k == 0, h && k == 1, h && !x[0], h && (x[0] || bhe)});
    bads_bus_master_i.stop();
    tick(6);
    chk(sel, 1'b0);
  endtask
  task automatic io(input logic [23:0] x, input int k, input logic [7:0] v, input logic [7:0] ex);
    bit h;
    h = io_hit(x);
    bads_bus_master_i.start(k, x, v, 1'b0, 1'b0);
    tick(6);
    chk(cs_n, !h);
    if (k == 2)
      chk({drv_n, rdat}, {!h, h ? ex : 8'h00});
    bads_bus_master_i.stop();
    tick(6);
  endtask
  task automatic pulse(input logic [1:0] e);
    @(posedge core_clk_i);
    perr <= e;
    @(posedge core_clk_i);
    perr <= 2'h0;
  endtask
  initial
  begin
    t = $urandom(14333);
    repeat (8) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    tick(2);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge core_clk_i);
      var_q <= (i == 0) ? BADS_CAP_32K : bads_variant_e'($urandom % 5);
      fd <= (i % 4 == 0);
      pg <= 4'($urandom);
      @(posedge core_clk_i);
      bnd <= 8'($urandom % (257 - (4 << var_q)));
      tick(3);
      mem(st(), i % 2);
      mem(st() + ('h4000 << var_q) - 1, 1);
      mem(st() + ('h4000 << var_q), 0);
      mem(st() - 1, 0);
      mem(st() ^ 'h100000, 1);
    end
    for (int i = 0; i < 12; i++)
    begin
      @(posedge core_clk_i);
      fd <= (i < 2);
      var_q <= (i == 2) ? BADS_CAP_16K : bads_variant_e'($urandom % 5);
      pdis <= (i == 2);
      {ioen, l6l, l6h, ll} <= 9'($urandom);
      tick(3);
      a = 24'($urandom);
      a[3:0] = fd ? 4'hF : ~ll;
      if (fd || ioen[2]) a[15:12] = 4'h0;
      if (fd || ioen[1]) a[11:8] = 4'h0;
      if (fd || ioen[0]) a[7:4] = {1'b0, !fd && l6h && !l6l, 2'b00};
      d = 8'($urandom);
      e2 = 2'($urandom);
      pulse(2'h3);
      io(a, 3, d, 8'h00);
      if (io_hit(a)) ty = d[5:4];
      chk(ptype, ty);
      pulse(e2);
      io(a, 2, 8'h00, {2'b00, ty, 2'b00, e2});
      io(a ^ 24'h000001, 2, 8'h00, 8'h00);
    end
    @(posedge core_clk_i);
    var_q <= BADS_CAP_64K;
    fd <= 1'b0;
    dly <= 1'b0;
    adv <= 1'b1;
    pg <= 4'h0;
    bnd <= 8'h00;
    tick(3);
    bads_bus_master_i.start(1, 24'h000100, 8'h3C, 1'b1, 1'b1);
    for (t = 0; t < 40 && wrq !== 1'b1; t++) tick(1);
    if (t == 40)
    begin
      miscompares++;
    end
    chk(16'(wr_at - sel_at), 16'd20);
    bads_bus_master_i.stop();
    tick(6);
    t = wr_at;
    bads_bus_master_i.start(1, 24'h000200, 8'h3C, 1'b0, 1'b1);
    bads_bus_master_i.stop();
    tick(30);
    chk(16'(wr_at - t), 16'd0);
    close_out();
  end
endmodule
